/* File: rtl/fph_defines.svh */
// Offsets, field positions, codes and counts of the parameter channel
`ifndef FPH_DEFINES_SVH
`define FPH_DEFINES_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define FPH_CTRL_OFS 8'h00
`define FPH_STAT_OFS 8'h04
`define FPH_CNT_OFS 8'h08
`define FPH_RC_OFS 8'h0c

// ****************************************
// Management byte fields and codings
// ****************************************
`define FPH_SID_LSB 0
`define FPH_SID_MSB 3
`define FPH_LEN_LSB 4
`define FPH_LEN_MSB 5
`define FPH_HS_BIT 6
`define FPH_ERR_BIT 7
`define FPH_SID_READ 4'h1
`define FPH_SID_WRITE 4'h2
`define FPH_LEN_FOUR 2'h3
`define FPH_RSVD_VAL 8'h00

// ****************************************
// Return codes
// ****************************************
`define FPH_CLS_SERVICE 8'h05
`define FPH_CLS_ACCESS 8'h06
`define FPH_CLS_OTHER 8'h08
`define FPH_EC_ILLEGAL 8'h05
`define FPH_EC_TYPE 8'h08
`define FPH_EC_HW 8'h02
`define FPH_EC_OTHER 8'h00
`define FPH_AC_NONE 8'h00
`define FPH_AC_FIRST 8'h10
`define FPH_AC_LOCK 8'h13
`define FPH_AC_SYSSW 8'h18
`define FPH_AC_LAST 8'h20

// ****************************************
// Reset values and counts
// ****************************************
`define FPH_CTRL_RST 1'b0
`define FPH_TIMEOUT 4000
`endif

/* File: rtl/fph_pkg.sv */
// Types shared by the parameter channel handler and its users
package fph_pkg;

    // Eight-byte channel, byte 0 in the top bits
    typedef struct packed {
        logic [7:0] mgmt;
        logic [7:0] rsvd;
        logic [15:0] index;
        logic [31:0] data;
    } fph_chan_type;

    // Service handed to the parameter store
    typedef struct packed {
        logic write;
        logic [15:0] index;
        logic [31:0] wdata;
    } fph_req_type;

    // Execution states
    typedef enum logic [0:0] {
        FPH_IDLE = 1'b0,
        FPH_WAIT = 1'b1
    } fph_state_type;
endpackage

/* File: rtl/fph_param_channel.sv */
// Parameter channel handler: decodes, executes and answers services
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "fph_defines.svh"

// Notes on behaviour
// - management byte: id, length, handshake, error
// - data right-justified, byte 7 least significant
// - failure sets flag, return code in bytes 4-7
// - error classes one to eight
// - drive-side failures reported as class 8
// - class 8 uses error code zero
// - additional high zero; low codes 00,10-12,1B,1C
// - codes 15, 16, 1D for bad values
// - codes 13, 14, 1E for lock, factory
// - codes 17, 18 for option, software
// - codes 1F, 20 for storage, output stage
// - codes 19, 1A for interface-only access
// - bad service coding gives 5/5/0
// - write length not four gives 6/8/0
// - internal failure gives 6/2/0, master retries
// - read ignores data and length bits
// - write always uses four-byte length
// - no toggle means echo only
// - old handshake returned while executing
// - toggled handshake signals completion
module fph_param_channel
    import fph_pkg::*;
#(
    parameter int TIMEOUT = `FPH_TIMEOUT
) (
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Cyclic channel from and to the fieldbus side
    input wire logic chan_valid,
    input wire fph_chan_type chan_in,
    output fph_chan_type chan_out,
    // Parameter store
    output logic be_valid,
    output fph_req_type be_req,
    input wire logic be_done,
    input wire logic be_fail,
    input wire logic [7:0] be_code,
    input wire logic [31:0] be_rdata
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (TIMEOUT < 2 || TIMEOUT > 65535) begin : g_chk
        $error("TIMEOUT out of range");
    end

    // ****************************************
    // Declarations
    // ****************************************
    fph_state_type state; // Execution state
    logic hs_seen; // Last handshake received
    logic hs_out; // Handshake returned
    logic held; // Answer frozen after completion
    logic lock; // Software parameter lock
    logic [15:0] tmo; // Watchdog on the store
    logic [15:0] done_cnt; // Completed services
    logic [31:0] last_rc; // Last return code
    logic last_err; // Last service failed
    fph_chan_type req; // Request captured at toggle
    logic toggle; // New service arrives
    logic [3:0] sid; // Service identifier
    logic [1:0] len; // Write length code
    logic bad_code; // Illegal coding
    logic bad_len; // Wrong write length
    logic locked; // Write refused by lock
    logic imm; // Finishes without the store
    logic fin; // Service completes now
    logic fin_err; // Completing service failed
    logic [31:0] fin_data; // Data or return code
    logic apb_rd; // Setup cycle of a read
    logic apb_wr; // Access cycle of a write
    logic hit; // Mapped address

    // Management fields of the incoming channel
    assign sid = chan_in.mgmt[`FPH_SID_MSB:`FPH_SID_LSB];
    assign len = chan_in.mgmt[`FPH_LEN_MSB:`FPH_LEN_LSB];

    // Only a handshake change starts a service
    assign toggle = chan_valid && state == FPH_IDLE &&
        chan_in.mgmt[`FPH_HS_BIT] != hs_seen;

    // ****************************************
    // Decode of a new service
    // ****************************************
    // Reserved byte or unknown identifier is a coding error
    always_comb begin
        bad_code = chan_in.rsvd != `FPH_RSVD_VAL ||
            (sid != `FPH_SID_READ && sid != `FPH_SID_WRITE);
        // Length matters only for writes; reads ignore it
        bad_len = sid == `FPH_SID_WRITE &&
            len != `FPH_LEN_FOUR;
        locked = sid == `FPH_SID_WRITE && lock;
        imm = bad_code || bad_len || locked;
    end

    // ****************************************
    // Completion and return code
    // ****************************************
    // Maps store answers and decode faults to the return code
    always_comb begin
        fin = 1'b0;
        fin_err = 1'b0;
        fin_data = req.data;
        if (toggle && imm) begin
            fin = 1'b1;
            fin_err = 1'b1;
            if (bad_code) begin
                // Class, code, additional high, low
                fin_data = {`FPH_CLS_SERVICE, `FPH_EC_ILLEGAL,
                    `FPH_AC_NONE, `FPH_AC_NONE};
            end else if (bad_len) begin
                fin_data = {`FPH_CLS_ACCESS, `FPH_EC_TYPE,
                    `FPH_AC_NONE, `FPH_AC_NONE};
            end else begin
                fin_data = {`FPH_CLS_OTHER, `FPH_EC_OTHER,
                    `FPH_AC_NONE, `FPH_AC_LOCK};
            end
        end else if (state == FPH_WAIT) begin
            if (be_fail || tmo == 16'h0000) begin
                // A hung store counts as an internal failure
                fin = 1'b1;
                fin_err = 1'b1;
                fin_data = {`FPH_CLS_ACCESS, `FPH_EC_HW,
                    `FPH_AC_NONE, `FPH_AC_NONE};
            end else if (be_done && be_code != `FPH_AC_NONE) begin
                fin = 1'b1;
                fin_err = 1'b1;
                // Unknown store codes become a software error
                if (be_code >= `FPH_AC_FIRST &&
                    be_code <= `FPH_AC_LAST) begin
                    fin_data = {`FPH_CLS_OTHER, `FPH_EC_OTHER,
                        `FPH_AC_NONE, be_code};
                end else begin
                    fin_data = {`FPH_CLS_OTHER, `FPH_EC_OTHER,
                        `FPH_AC_NONE, `FPH_AC_SYSSW};
                end
            end else if (be_done) begin
                fin = 1'b1;
                // Read returns value, byte 7 least significant
                fin_data = req.mgmt[`FPH_SID_MSB:`FPH_SID_LSB] ==
                    `FPH_SID_READ ? be_rdata : req.data;
            end
        end
    end

    // ****************************************
    // Execution state machine
    // ****************************************
    // Waits on the store; toggles while busy are ignored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= FPH_IDLE;
        end else begin
            case (state)
                FPH_IDLE: begin
                    if (toggle && !imm) begin
                        state <= FPH_WAIT;
                    end
                end
                FPH_WAIT: begin
                    if (fin) begin
                        state <= FPH_IDLE;
                    end
                end
                default: begin
                    state <= FPH_IDLE;
                end
            endcase
        end
    end

    // Captures the request and the new handshake
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hs_seen <= 1'b0;
            req <= '0;
        end else if (toggle) begin
            hs_seen <= chan_in.mgmt[`FPH_HS_BIT];
            req <= chan_in;
        end
    end

    // Store request, one-cycle pulse at the start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            be_valid <= 1'b0;
            be_req <= '0;
        end else begin
            be_valid <= toggle && !imm;
            if (toggle && !imm) begin
                be_req.write <= sid == `FPH_SID_WRITE;
                be_req.index <= chan_in.index;
                be_req.wdata <= chan_in.data;
            end
        end
    end

    // Watchdog so a silent store cannot hang the channel
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tmo <= 16'hffff;
        end else if (toggle) begin
            tmo <= 16'(TIMEOUT);
        end else if (state == FPH_WAIT && tmo != 16'h0000) begin
            tmo <= tmo - 16'h0001;
        end
    end

    // ****************************************
    // Response channel
    // ****************************************
    // Old handshake until completion, then the new one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hs_out <= 1'b0;
            held <= 1'b0;
        end else if (fin) begin
            hs_out <= toggle ? chan_in.mgmt[`FPH_HS_BIT] :
                hs_seen;
            held <= 1'b1;
        end else if (toggle) begin
            held <= 1'b0;
        end
    end

    // Echo while idle or busy, frozen answer after completion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chan_out <= '0;
        end else if (fin) begin
            chan_out.mgmt <= {fin_err,
                toggle ? chan_in.mgmt[`FPH_HS_BIT] : hs_seen,
                toggle ? chan_in.mgmt[5:0] : req.mgmt[5:0]};
            chan_out.rsvd <= `FPH_RSVD_VAL;
            chan_out.index <= toggle ? chan_in.index : req.index;
            chan_out.data <= fin_data;
        end else if (chan_valid && (!held || toggle)) begin
            chan_out <= chan_in;
            chan_out.mgmt[`FPH_HS_BIT] <= hs_out;
            chan_out.mgmt[`FPH_ERR_BIT] <= 1'b0;
        end
    end

    // ****************************************
    // Statistics for software
    // ****************************************
    // Counts completions and keeps the last return code
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_cnt <= 16'h0000;
            last_rc <= 32'h00000000;
            last_err <= 1'b0;
        end else if (fin) begin
            done_cnt <= done_cnt + 16'h0001;
            last_err <= fin_err;
            last_rc <= fin_err ? fin_data : 32'h00000000;
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    // Zero wait states; unmapped offsets answer with an error
    always_comb begin
        hit = paddr == `FPH_CTRL_OFS || paddr == `FPH_STAT_OFS ||
            paddr == `FPH_CNT_OFS || paddr == `FPH_RC_OFS;
        apb_rd = psel && !penable && !pwrite;
        apb_wr = psel && penable && pwrite;
        pready = psel && penable;
        pslverr = psel && penable && !hit;
    end

    // Control: bit 0 locks parameter writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock <= `FPH_CTRL_RST;
        end else if (apb_wr && paddr == `FPH_CTRL_OFS) begin
            lock <= pwdata[0];
        end
    end

    // Read data is fetched in the setup cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (apb_rd) begin
            case (paddr)
                `FPH_CTRL_OFS: prdata <= {31'h0, lock};
                `FPH_STAT_OFS: prdata <= {28'h0, last_err, held,
                    hs_out, state == FPH_WAIT};
                `FPH_CNT_OFS: prdata <= {16'h0, done_cnt};
                `FPH_RC_OFS: prdata <= last_rc;
                default: prdata <= 32'h00000000;
            endcase
        end
    end

endmodule

/* File: testbench/fph_param_channel_asserts.sv */
// Port checker for the parameter channel handler
`timescale 1ns/100ps
module fph_param_channel_asserts
    import fph_pkg::*;
#(
    parameter int TIMEOUT = 4000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chan_valid,
    input wire fph_chan_type chan_in,
    input wire fph_chan_type chan_out,
    input wire logic be_valid,
    input wire fph_req_type be_req,
    input wire logic be_done,
    input wire logic be_fail,
    input wire logic [7:0] be_code,
    input wire logic [31:0] be_rdata
);
    // ****************************************
    // Busy tracking
    // ****************************************
    logic busy; // Store service outstanding
    logic hs_q; // Returned handshake one cycle ago
    logic bsy; // Cleared as soon as the returned handshake moves
    logic fin_q; // An answer stands since the last completion
    logic ans; // Answer held: no echo may overwrite it
    logic [15:0] bcnt; // Cycles since the store hand-off
    assign bsy = be_valid || (busy && chan_out.mgmt[6] == hs_q);
    assign ans = fin_q || chan_out.mgmt[6] != hs_q;
    // Set on hand-off, cleared when the answer toggles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            hs_q <= 1'b0;
        end else begin
            hs_q <= chan_out.mgmt[6];
            busy <= be_valid || (busy && chan_out.mgmt[6] == hs_q);
        end
    end
    // Set by a completion, cleared by the next accepted toggle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fin_q <= 1'b0;
        end else if (chan_valid && !bsy &&
            chan_in.mgmt[6] != chan_out.mgmt[6]) begin
            fin_q <= 1'b0;
        end else if (chan_out.mgmt[6] != hs_q) begin
            fin_q <= 1'b1;
        end
    end
    // Counts from the hand-off so the watchdog cycle is known
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bcnt <= 16'h0000;
        end else if (be_valid) begin
            bcnt <= 16'h0002;
        end else if (bcnt != 16'hffff) begin
            bcnt <= bcnt + 16'h0001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_toggle;
        chan_valid && !bsy && chan_in.mgmt[6] != chan_out.mgmt[6];
    endsequence
    sequence s_read_ok;
        bsy && be_done && !be_fail && be_code == 8'h00 && !be_req.write;
    endsequence
    // ****************************************
    // Assertions
    // ****************************************
    a_ready_follow: assert property (pready == (psel && penable))
        else $error("pready does not follow access phase");
    a_unmapped_err: assert property (psel && penable |->
        pslverr == (paddr > 8'h0c || paddr[1:0] != 2'b00))
        else $error("pslverr wrong for address");
    a_idle_echo: assert property (chan_valid && !bsy &&
        chan_in.mgmt[6] == chan_out.mgmt[6] |=> !be_valid)
        else $error("service started without toggle");
    a_read_start: assert property (s_toggle ##0
        (chan_in.rsvd == 8'h00 && chan_in.mgmt[3:0] == 4'h1) |=>
        be_valid && !be_req.write && be_req.index == $past(chan_in.index))
        else $error("read not started");
    a_bad_coding: assert property (s_toggle ##0 (chan_in.rsvd != 8'h00 ||
        (chan_in.mgmt[3:0] != 4'h1 && chan_in.mgmt[3:0] != 4'h2)) |=>
        chan_out.mgmt[7] && chan_out.data == 32'h05050000 && !be_valid)
        else $error("bad coding answer wrong");
    a_bad_length: assert property (s_toggle ##0 (chan_in.rsvd == 8'h00 &&
        chan_in.mgmt[3:0] == 4'h2 && chan_in.mgmt[5:4] != 2'h3) |=>
        chan_out.mgmt[7] && chan_out.data == 32'h06080000)
        else $error("bad length answer wrong");
    a_store_code: assert property (bsy && be_done &&
        be_code >= 8'h10 && be_code <= 8'h20 |=> chan_out.mgmt[7] &&
        chan_out.data == {24'h080000, $past(be_code)})
        else $error("store code answer wrong");
    a_fail_code: assert property (bsy && be_fail |=>
        chan_out.mgmt[7] && chan_out.data == 32'h06020000)
        else $error("internal failure answer wrong");
    a_read_answer: assert property (s_read_ok |=>
        chan_out.data == $past(be_rdata) && !chan_out.mgmt[7] &&
        chan_out.mgmt[6] != $past(chan_out.mgmt[6]))
        else $error("read answer wrong");
    a_busy_echo: assert property (bsy && chan_valid &&
        !be_done && !be_fail && (be_valid || bcnt <= TIMEOUT) |=>
        !chan_out.mgmt[7] &&
        chan_out.mgmt[6] == $past(chan_out.mgmt[6]))
        else $error("handshake moved while busy");
    a_idle_hold: assert property (((!bsy && !chan_valid) ||
        (ans && !(chan_valid && chan_in.mgmt[6] != chan_out.mgmt[6])))
        |=> $stable(chan_out))
        else $error("answer not held");
    a_write_start: assert property (s_toggle ##0
        (chan_in.rsvd == 8'h00 && chan_in.mgmt[5:0] == 6'h32) |=>
        (be_valid ? (be_req.write && be_req.wdata == $past(chan_in.data)) :
        chan_out.data == 32'h08000013))
        else $error("write not started");
    a_store_timeout: assert property (bsy && !be_valid &&
        bcnt == TIMEOUT + 1 |=> chan_out.mgmt[7] &&
        chan_out.data == 32'h06020000)
        else $error("store timeout answer wrong");
endmodule
bind fph_param_channel fph_param_channel_asserts #(.TIMEOUT(TIMEOUT)) u_chk (
    .clk, .rst, .psel, .penable, .paddr, .pready, .pslverr, .chan_valid,
    .chan_in, .chan_out, .be_valid, .be_req, .be_done, .be_fail, .be_code,
    .be_rdata);

/* File: testbench/fph_master_model.sv */
// Cyclic fieldbus master sending the parameter channel
`timescale 1ns/100ps
module fph_master_model
    import fph_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire fph_chan_type chan_set,
    output logic chan_valid,
    output fph_chan_type chan_in
);
    logic [1:0] tick; // Cycle slot, one word every four clocks
    // Whole word sent in one slot; garbage between slots
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick <= 2'h0;
            chan_valid <= 1'b0;
            chan_in <= '0;
        end else begin
            tick <= tick + 2'h1;
            chan_valid <= tick == 2'h3;
            chan_in <= tick == 2'h3 ? chan_set : ~chan_set;
        end
    end
endmodule

/* File: testbench/fph_param_channel_tb.sv */
// Testbench for the parameter channel handler
`timescale 1ns/100ps
`include "fph_defines.svh"
module fph_param_channel_tb
    import fph_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, chan_valid, be_valid, hs = 1'b0;
    fph_chan_type chan_set = '0, chan_in, chan_out;
    fph_req_type be_req;
    logic be_done = 1'b0, be_fail = 1'b0, st_mode = 1'b0, st_mute = 1'b0;
    logic [7:0] be_code = 8'h00, st_code = 8'h00;
    logic [31:0] be_rdata = 32'h0, st_rdata = 32'h1234abcd, rd;
    logic [3:0] st_cnt = 4'h0; // Store delay counter
    logic er;
    int mismatches = 0, n_checks = 0, cyc = 0;
    always #12.5 clk = ~clk;
    fph_param_channel #(.TIMEOUT(40)) u_dut (.clk(clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_valid(chan_valid), .chan_in(chan_in),
        .chan_out(chan_out), .be_valid(be_valid), .be_req(be_req),
        .be_done(be_done), .be_fail(be_fail), .be_code(be_code),
        .be_rdata(be_rdata));
    fph_master_model u_mst (.clk(clk), .rst(rst), .chan_set(chan_set),
        .chan_valid(chan_valid), .chan_in(chan_in));
    // Store answers seven cycles after hand-off, never when muted
    always @(posedge clk) begin
        be_done <= st_cnt == 4'h1 && !st_mode && !st_mute;
        be_fail <= st_cnt == 4'h1 && st_mode && !st_mute;
        be_code <= st_cnt == 4'h1 ? st_code : ~st_code;
        be_rdata <= st_cnt == 4'h1 ? st_rdata : ~st_rdata;
        st_cnt <= be_valid ? 4'h6 : (st_cnt != 0 ? st_cnt - 4'h1 : 4'h0);
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // APB transfer, request held until pready
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // pready ends this wait; the hang guard ends a stall
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Channel set up piecewise, handshake toggled last, answer judged
    task automatic svc(input logic [7:0] m, rs, input logic [15:0] ix,
        input logic [31:0] d, input logic ee, input logic [31:0] ed);
        @(posedge clk);
        chan_set.index <= ix;
        repeat (5) @(posedge clk);
        chan_set.data <= d;
        chan_set.rsvd <= rs;
        repeat (5) @(posedge clk);
        chan_set.mgmt <= {1'b0, hs, m[5:0]};
        repeat (5) @(posedge clk);
        hs = ~hs;
        chan_set.mgmt[6] <= hs;
        // Completion is equal handshakes; the hang guard ends a stall
        do begin
            @(posedge clk);
        end while (chan_out.mgmt[6] !== hs);
        repeat (6) @(posedge clk);
        chk("mgmt", {ee, hs, m[5:0]}, chan_out.mgmt);
        chk("index", ix, chan_out.index);
        chk("data", ed, chan_out.data);
    endtask
    task automatic t_regs();
        apb(1'b0, `FPH_CTRL_OFS, 32'h0);
        chk("ctrl", 32'h0, rd);
        apb(1'b1, `FPH_CNT_OFS, 32'hffff);
        apb(1'b0, `FPH_CNT_OFS, 32'h0);
        chk("count ro", 32'h0, rd);
        apb(1'b1, 8'h10, 32'h1);
        chk("unmapped wr", 1'b1, er);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped rd", {1'b1, 32'h0}, {er, rd});
    endtask
    task automatic t_reads();
        svc(8'h01, 8'h00, 16'h2001, 32'hffffffff, 1'b0, st_rdata);
        svc(8'h31, 8'h00, 16'h2002, 32'h0, 1'b0, st_rdata);
        svc(8'h32, 8'h00, 16'h2003, 32'h89abcdef, 1'b0, 32'h89abcdef);
        apb(1'b0, `FPH_CNT_OFS, 32'h0);
        chk("count", 32'h3, rd);
        apb(1'b0, `FPH_STAT_OFS, 32'h0);
        chk("status", {28'h0, 2'b01, hs, 1'b0}, rd);
    endtask
    task automatic t_codes();
        for (int c = 8'h10; c <= 8'h20; c++) begin
            st_code = c[7:0];
            svc(8'h01, 8'h00, 16'h2004, 32'h0, 1'b1, {24'h080000, c[7:0]});
        end
        // Codes outside the table fall back to a software error
        st_code = 8'h21;
        svc(8'h01, 8'h00, 16'h2004, 32'h0, 1'b1, 32'h08000018);
        st_code = 8'h00;
    endtask
    task automatic t_bad();
        svc(8'h01, 8'h01, 16'h2005, 32'h0, 1'b1, 32'h05050000);
        svc(8'h03, 8'h00, 16'h2005, 32'h0, 1'b1, 32'h05050000);
        svc(8'h22, 8'h00, 16'h2005, 32'h0, 1'b1, 32'h06080000);
        apb(1'b1, `FPH_CTRL_OFS, 32'h1);
        apb(1'b0, `FPH_CTRL_OFS, 32'h0);
        chk("lock", 32'h1, rd);
        svc(8'h32, 8'h00, 16'h2006, 32'h5, 1'b1, 32'h08000013);
        apb(1'b1, `FPH_CTRL_OFS, 32'h0);
    endtask
    task automatic t_fail();
        st_mode = 1'b1;
        svc(8'h01, 8'h00, 16'h2007, 32'h0, 1'b1, 32'h06020000);
        apb(1'b0, `FPH_RC_OFS, 32'h0);
        chk("lastrc", 32'h06020000, rd);
        st_mode = 1'b0;
        svc(8'h01, 8'h00, 16'h2007, 32'h0, 1'b0, st_rdata);
        // A silent store must end in the watchdog's failure answer
        st_mute = 1'b1;
        svc(8'h01, 8'h00, 16'h2008, 32'h0, 1'b1, 32'h06020000);
        st_mute = 1'b0;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_reads();
        t_codes();
        t_bad();
        t_fail();
        results();
    end
endmodule
